// *** gpp_group.v ***
`include "gpp_map.vh"

module gpp_group (
  // Clock and reset
  input  wire        mclk,
  input  wire        reset,
  // Register writes
  input  wire        wr_en,
  input  wire [2:0]  wr_sel,
  input  wire [15:0] wr_data,
  // Pins
  input  wire [7:0]  pin_in,
  input  wire [7:0]  present,
  // Register contents
  output reg  [7:0]  out_latch_q,
  output reg  [7:0]  in_sample_q,
  output reg  [7:0]  in_en_q,
  output reg  [7:0]  out_en_q,
  output reg  [7:0]  pull_dir_q,
  output reg  [7:0]  pull_en_q,
  output reg  [7:0]  irq_flag_q,
  output reg  [7:0]  edge_sel_q,
  output reg  [7:0]  irq_en_q,
  output reg  [7:0]  debounce_q,
  output reg  [7:0]  periph_sel_q,
  output reg  [15:0] func_code_q
);

  reg  [7:0] prev_q;
  wire [7:0] hi = wr_data[15:`GPP_HI_LSB] & present;
  wire [7:0] lo = wr_data[7:`GPP_LO_LSB] & present;
  wire [15:0] fmask = {{2{present[7]}}, {2{present[6]}}, {2{present[5]}}, {2{present[4]}},
                       {2{present[3]}}, {2{present[2]}}, {2{present[1]}}, {2{present[0]}}};
  wire [7:0] in_now = pin_in & in_en_q & present;
  wire [7:0] rise = in_now & ~prev_q;
  wire [7:0] fall = ~in_now & prev_q;
  wire [7:0] evt = ((rise & ~edge_sel_q) | (fall & edge_sel_q)) & present;
  wire [7:0] clr = (wr_en && wr_sel == 3'h3) ? lo : 8'h00;

  always @(posedge mclk) begin
    if (reset) begin
      out_latch_q  <= `GPP_RST8;
      in_sample_q  <= `GPP_RST8;
      in_en_q      <= `GPP_RST8;
      out_en_q     <= `GPP_RST8;
      pull_dir_q   <= `GPP_RST8;
      pull_en_q    <= `GPP_RST8;
      irq_flag_q   <= `GPP_RST8;
      edge_sel_q   <= `GPP_RST8;
      irq_en_q     <= `GPP_RST8;
      debounce_q   <= `GPP_RST8;
      periph_sel_q <= `GPP_RST8;
      func_code_q  <= `GPP_RST16;
      prev_q       <= `GPP_RST8;
    end else begin
      in_sample_q <= in_now;
      prev_q      <= in_now;
      irq_flag_q  <= (irq_flag_q & ~clr) | evt;
      if (wr_en) begin
        case (wr_sel)
          3'h0: out_latch_q <= hi;
          3'h1: begin
            in_en_q  <= hi;
            out_en_q <= lo;
          end
          3'h2: begin
            pull_dir_q <= hi;
            pull_en_q  <= lo;
          end
          3'h4: begin
            edge_sel_q <= hi;
            irq_en_q   <= lo;
          end
          3'h5: debounce_q <= lo;
          3'h6: periph_sel_q <= lo;
          3'h7: func_code_q <= wr_data & fmask;
          default: ;
        endcase
      end
    end
  end

endmodule // gpp_group

// *** gpp_map.vh ***
`ifndef GPP_MAP_VH
`define GPP_MAP_VH
// Register indices (16-bit registers, index addressing)
`define GPP_AW            4
`define GPP_P2_PIN_DATA   4'h0
`define GPP_P2_DIR_EN     4'h1
`define GPP_P2_PULL       4'h2
`define GPP_P2_IRQ_FLAGS  4'h3
`define GPP_P2_IRQ_CTL    4'h4
`define GPP_P2_DEBOUNCE   4'h5
`define GPP_P2_MODE_SEL   4'h6
`define GPP_P2_FUNC_SEL   4'h7
`define GPP_P3_PIN_DATA   4'h8
`define GPP_P3_DIR_EN     4'h9
`define GPP_P3_PULL       4'ha
`define GPP_P3_IRQ_FLAGS  4'hb
`define GPP_P3_IRQ_CTL    4'hc
`define GPP_P3_DEBOUNCE   4'hd
`define GPP_P3_MODE_SEL   4'he
`define GPP_P3_FUNC_SEL   4'hf
// Field positions
`define GPP_HI_LSB        8
`define GPP_LO_LSB        0
// Reset values
`define GPP_RST8          8'h00
`define GPP_RST16         16'h0000
// Function codes
`define GPP_FN0           2'h0
`define GPP_FN1           2'h1
`define GPP_FN2           2'h2
`define GPP_FN3           2'h3
// Pins present in the small package for group three
`define GPP_P3_SMALL_MASK 8'ha7
`endif

// *** gpp_pin_model.sv ***
module gpp_pin_model (
  // Clock
  input  logic        mclk,
  // External drivers, group two low byte, group three high byte
  input  logic [15:0] ext_en,
  input  logic [15:0] ext_val,
  // Device pin side
  input  logic [15:0] pin_out,
  input  logic [15:0] pin_oe,
  input  logic [15:0] pull_up,
  input  logic [15:0] pull_down,
  output logic [15:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic tog = 1'b0;
  // Floating pins wander so a stale level never passes
  always @(posedge mclk) tog <= ~tog;
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ((ext_en & ext_val)
    | (~ext_en & (pull_up | (~pull_down & {16{tog}})))));
endmodule // gpp_pin_model

// *** gpp_port.v ***
// Strobed register access and the register addresses are this design's own decisions.
`include "gpp_map.vh"

module gpp_port (
  // Clock and reset
  input  wire        mclk,
  input  wire        reset,
  // Package strap, high for the small package
  input  wire        small_pkg,
  // Register port
  input  wire [3:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [15:0] reg_rdata,
  // Pins
  input  wire [7:0]  grp2_pin_in,
  output reg  [7:0]  grp2_pin_out,
  output reg  [7:0]  grp2_pin_oe,
  output reg  [7:0]  grp2_pull_up,
  output reg  [7:0]  grp2_pull_down,
  input  wire [7:0]  grp3_pin_in,
  output reg  [7:0]  grp3_pin_out,
  output reg  [7:0]  grp3_pin_oe,
  output reg  [7:0]  grp3_pull_up,
  output reg  [7:0]  grp3_pull_down,
  // Peripheral side: grp2 functions
  input  wire [7:0]  grp2_fn0_out,
  input  wire [7:0]  grp2_fn0_oe,
  output reg  [7:0]  grp2_fn0_sel,
  input  wire [7:0]  grp2_universal_port_multiplexer_out,
  input  wire [7:0]  grp2_universal_port_multiplexer_oe,
  output reg  [7:0]  grp2_universal_port_multiplexer_sel,
  input  wire [7:0]  grp2_seg_out,
  output reg  [7:0]  grp2_seg_sel,
  output reg  [7:0]  grp2_periph_in,
  // Peripheral side: grp3 functions
  input  wire [7:0]  grp3_universal_port_multiplexer_out,
  input  wire [7:0]  grp3_universal_port_multiplexer_oe,
  output reg  [7:0]  grp3_universal_port_multiplexer_sel,
  output reg  [7:0]  grp3_periph_in,
  // Interrupts
  output reg         grp2_irq,
  output reg         grp3_irq
);

  wire [7:0]  g2_out, g2_in, g2_ien, g2_oen, g2_pd, g2_pe, g2_if, g2_ed, g2_ie, g2_db, g2_sel;
  wire [7:0]  g3_out, g3_in, g3_ien, g3_oen, g3_pd, g3_pe, g3_if, g3_ed, g3_ie, g3_db, g3_sel;
  wire [15:0] g2_fn, g3_fn;
  reg  [7:0]  p3_present_q;

  always @(posedge mclk) begin
    if (reset)
      p3_present_q <= 8'hff;
    else
      p3_present_q <= small_pkg ? `GPP_P3_SMALL_MASK : 8'hff;
  end

  gpp_group u_grp2 (
    .mclk(mclk), .reset(reset),
    .wr_en(reg_wr && !reg_addr[3]), .wr_sel(reg_addr[2:0]), .wr_data(reg_wdata),
    .pin_in(grp2_pin_in), .present(8'hff),
    .out_latch_q(g2_out), .in_sample_q(g2_in), .in_en_q(g2_ien), .out_en_q(g2_oen),
    .pull_dir_q(g2_pd), .pull_en_q(g2_pe), .irq_flag_q(g2_if), .edge_sel_q(g2_ed),
    .irq_en_q(g2_ie), .debounce_q(g2_db), .periph_sel_q(g2_sel), .func_code_q(g2_fn)
  );

  gpp_group u_grp3 (
    .mclk(mclk), .reset(reset),
    .wr_en(reg_wr && reg_addr[3]), .wr_sel(reg_addr[2:0]), .wr_data(reg_wdata),
    .pin_in(grp3_pin_in), .present(p3_present_q),
    .out_latch_q(g3_out), .in_sample_q(g3_in), .in_en_q(g3_ien), .out_en_q(g3_oen),
    .pull_dir_q(g3_pd), .pull_en_q(g3_pe), .irq_flag_q(g3_if), .edge_sel_q(g3_ed),
    .irq_en_q(g3_ie), .debounce_q(g3_db), .periph_sel_q(g3_sel), .func_code_q(g3_fn)
  );

  // Pin muxing, combinational then registered
  reg [7:0] g2_o_d, g2_oe_d, g2_f0_d, g2_f1_d, g2_f3_d;
  reg [7:0] g3_o_d, g3_oe_d, g3_f1_d;
  reg [1:0] c2, c3;
  integer   i;

  always @* begin
    g2_o_d  = 8'h00;
    g2_oe_d = 8'h00;
    g2_f0_d = 8'h00;
    g2_f1_d = 8'h00;
    g2_f3_d = 8'h00;
    g3_o_d  = 8'h00;
    g3_oe_d = 8'h00;
    g3_f1_d = 8'h00;
    c2      = 2'h0;
    c3      = 2'h0;
    for (i = 0; i < 8; i = i + 1) begin
      c2 = g2_fn[2*i +: 2];
      c3 = g3_fn[2*i +: 2];
      if (!g2_sel[i]) begin
        g2_o_d[i]  = g2_out[i];
        g2_oe_d[i] = g2_oen[i];
      end else begin
        case (c2)
          `GPP_FN0: begin
            g2_f0_d[i] = 1'b1;
            g2_o_d[i]  = grp2_fn0_out[i];
            g2_oe_d[i] = grp2_fn0_oe[i];
          end
          `GPP_FN1: begin
            g2_f1_d[i] = 1'b1;
            g2_o_d[i]  = grp2_universal_port_multiplexer_out[i];
            g2_oe_d[i] = grp2_universal_port_multiplexer_oe[i];
          end
          `GPP_FN3: begin
            g2_f3_d[i] = 1'b1;
            g2_o_d[i]  = grp2_seg_out[i];
            g2_oe_d[i] = 1'b1;
          end
          default: ;
        endcase
      end
      if (!g3_sel[i]) begin
        g3_o_d[i]  = g3_out[i];
        g3_oe_d[i] = g3_oen[i];
      end else if (c3 == `GPP_FN1) begin
        g3_f1_d[i] = 1'b1;
        g3_o_d[i]  = grp3_universal_port_multiplexer_out[i];
        g3_oe_d[i] = grp3_universal_port_multiplexer_oe[i];
      end
    end
  end

  // Read mux
  reg [15:0] rd_d;
  always @* begin
    case (reg_addr)
      `GPP_P2_PIN_DATA:  rd_d = {g2_out, g2_in};
      `GPP_P2_DIR_EN:    rd_d = {g2_ien, g2_oen};
      `GPP_P2_PULL:      rd_d = {g2_pd, g2_pe};
      `GPP_P2_IRQ_FLAGS: rd_d = {8'h00, g2_if};
      `GPP_P2_IRQ_CTL:   rd_d = {g2_ed, g2_ie};
      `GPP_P2_DEBOUNCE:  rd_d = {8'h00, g2_db};
      `GPP_P2_MODE_SEL:  rd_d = {8'h00, g2_sel};
      `GPP_P2_FUNC_SEL:  rd_d = g2_fn;
      `GPP_P3_PIN_DATA:  rd_d = {g3_out, g3_in};
      `GPP_P3_DIR_EN:    rd_d = {g3_ien, g3_oen};
      `GPP_P3_PULL:      rd_d = {g3_pd, g3_pe};
      `GPP_P3_IRQ_FLAGS: rd_d = {8'h00, g3_if};
      `GPP_P3_IRQ_CTL:   rd_d = {g3_ed, g3_ie};
      `GPP_P3_DEBOUNCE:  rd_d = {8'h00, g3_db};
      `GPP_P3_MODE_SEL:  rd_d = {8'h00, g3_sel};
      `GPP_P3_FUNC_SEL:  rd_d = g3_fn;
      default:           rd_d = `GPP_RST16;
    endcase
  end

  always @(posedge mclk) begin
    if (reset) begin
      reg_rdata      <= `GPP_RST16;
      grp2_pin_out   <= `GPP_RST8;
      grp2_pin_oe    <= `GPP_RST8;
      grp2_pull_up   <= `GPP_RST8;
      grp2_pull_down <= `GPP_RST8;
      grp3_pin_out   <= `GPP_RST8;
      grp3_pin_oe    <= `GPP_RST8;
      grp3_pull_up   <= `GPP_RST8;
      grp3_pull_down <= `GPP_RST8;
      grp2_fn0_sel   <= `GPP_RST8;
      grp2_universal_port_multiplexer_sel <= `GPP_RST8;
      grp2_seg_sel   <= `GPP_RST8;
      grp2_periph_in <= `GPP_RST8;
      grp3_universal_port_multiplexer_sel <= `GPP_RST8;
      grp3_periph_in <= `GPP_RST8;
      grp2_irq       <= 1'b0;
      grp3_irq       <= 1'b0;
    end else begin
      // Zero outside the read cycle keeps the bus quiet
      reg_rdata      <= reg_rd ? rd_d : `GPP_RST16;
      grp2_pin_out   <= g2_o_d;
      grp2_pin_oe    <= g2_oe_d;
      // Pull only applies while the pin is not driven
      grp2_pull_up   <= g2_pe & g2_pd & ~g2_oe_d;
      grp2_pull_down <= g2_pe & ~g2_pd & ~g2_oe_d;
      grp3_pin_out   <= g3_o_d & p3_present_q;
      grp3_pin_oe    <= g3_oe_d & p3_present_q;
      grp3_pull_up   <= g3_pe & g3_pd & ~g3_oe_d;
      grp3_pull_down <= g3_pe & ~g3_pd & ~g3_oe_d;
      grp2_fn0_sel   <= g2_f0_d;
      grp2_universal_port_multiplexer_sel <= g2_f1_d;
      grp2_seg_sel   <= g2_f3_d;
      grp2_periph_in <= grp2_pin_in & (g2_f0_d | g2_f1_d);
      grp3_universal_port_multiplexer_sel <= g3_f1_d;
      grp3_periph_in <= grp3_pin_in & g3_f1_d;
      grp2_irq       <= |(g2_if & g2_ie);
      grp3_irq       <= |(g3_if & g3_ie);
    end
  end

endmodule // gpp_port

// *** gpp_port_assertions.sv ***
`include "gpp_map.vh"
module gpp_port_assertions (
  // Clock, reset, strap
  input logic        mclk,
  input logic        reset,
  input logic        small_pkg,
  // Register port
  input logic [3:0]  reg_addr,
  input logic [15:0] reg_wdata,
  input logic        reg_wr,
  input logic        reg_rd,
  input logic [15:0] reg_rdata,
  // Pins and selects
  input logic [7:0]  grp2_pin_in,
  input logic [7:0]  grp2_pin_oe,
  input logic [7:0]  grp2_pull_up,
  input logic [7:0]  grp2_pull_down,
  input logic [7:0]  grp2_fn0_sel,
  input logic [7:0]  grp2_universal_port_multiplexer_sel,
  input logic [7:0]  grp2_seg_sel,
  input logic [7:0]  grp3_universal_port_multiplexer_sel,
  input logic        grp2_irq,
  input logic        grp3_irq
);
  default clocking cb @(posedge mclk); endclocking
  sequence s_ro_read;
    reg_rd && (reg_addr == `GPP_P2_IRQ_FLAGS || reg_addr == `GPP_P3_MODE_SEL);
  endsequence
  // Pins quiet around the clear, else a new edge wins
  sequence s_clear_all;
    reg_wr && reg_addr == `GPP_P2_IRQ_FLAGS && reg_wdata[7:0] == 8'hff
      && $stable(grp2_pin_in) ##1 $stable(grp2_pin_in);
  endsequence
  a_reset_clears:
  assert property (reset |=> !grp2_irq && !grp3_irq && grp2_pin_oe == 8'h00
    && grp3_universal_port_multiplexer_sel == 8'h00) else $error("outputs not cleared");
  a_ro_high_zero:
  assert property (disable iff (reset) s_ro_read |=> reg_rdata[15:8] == 8'h00)
    else $error("read-only byte not zero");
  a_clear_drops_irq:
  assert property (disable iff (reset) s_clear_all |=> !grp2_irq)
    else $error("irq after full clear");
  a_pull_exclusive:
  assert property (disable iff (reset) (grp2_pull_up & grp2_pull_down) == 8'h00)
    else $error("pull up and down together");
  a_pull_undriven:
  assert property (disable iff (reset)
    ((grp2_pull_up | grp2_pull_down) & grp2_pin_oe) == 8'h00) else $error("pull on driven pin");
  a_fn_exclusive:
  assert property (disable iff (reset) ((grp2_fn0_sel & grp2_universal_port_multiplexer_sel)
    | (grp2_fn0_sel & grp2_seg_sel) | (grp2_universal_port_multiplexer_sel & grp2_seg_sel)) == 8'h00)
    else $error("two functions on one pin");
  a_seg_drives:
  assert property (disable iff (reset) grp2_seg_sel != 8'h00 && $stable(grp2_seg_sel)
    |-> (grp2_pin_oe & grp2_seg_sel) == grp2_seg_sel) else $error("segment pin undriven");
  a_small_absent:
  assert property (disable iff (reset) small_pkg |-> (grp3_universal_port_multiplexer_sel & 8'h58) == 8'h00)
    else $error("absent pin selected");
endmodule // gpp_port_assertions

bind gpp_port gpp_port_assertions u_chk (.mclk(mclk), .reset(reset),
  .small_pkg(small_pkg), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .grp2_pin_in(grp2_pin_in),
  .grp2_pin_oe(grp2_pin_oe), .grp2_pull_up(grp2_pull_up), .grp2_pull_down(grp2_pull_down),
  .grp2_fn0_sel(grp2_fn0_sel), .grp2_universal_port_multiplexer_sel(grp2_universal_port_multiplexer_sel),
  .grp2_seg_sel(grp2_seg_sel), .grp3_universal_port_multiplexer_sel(grp3_universal_port_multiplexer_sel),
  .grp2_irq(grp2_irq), .grp3_irq(grp3_irq));

// *** gpp_port_tb_top.sv ***
`include "gpp_map.vh"
module gpp_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0, reset = 1'b1, small_pkg = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000, ext_en = 16'h0000, ext_val = 16'h0000;
  logic [15:0] reg_rdata, pin_in;
  logic [7:0] pv = 8'h36, poe = 8'hff;
  logic [7:0] g2_out, g2_oe, g2_pu, g2_pd, g3_out, g3_oe, g3_pu, g3_pd;
  logic [7:0] fn0_sel, up2_sel, seg_sel, up3_sel, pi2, pi3;
  logic g2_irq, g3_irq;
  int failures = 0, cmp_count = 0;
  always #2 mclk = ~mclk;
  gpp_port i_dut (.mclk(mclk), .reset(reset), .small_pkg(small_pkg),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .grp2_pin_in(pin_in[7:0]), .grp2_pin_out(g2_out),
    .grp2_pin_oe(g2_oe), .grp2_pull_up(g2_pu), .grp2_pull_down(g2_pd),
    .grp3_pin_in(pin_in[15:8]), .grp3_pin_out(g3_out), .grp3_pin_oe(g3_oe),
    .grp3_pull_up(g3_pu), .grp3_pull_down(g3_pd), .grp2_fn0_out(pv),
    .grp2_fn0_oe(poe), .grp2_fn0_sel(fn0_sel), .grp2_universal_port_multiplexer_out(~pv),
    .grp2_universal_port_multiplexer_oe(poe), .grp2_universal_port_multiplexer_sel(up2_sel), .grp2_seg_out({pv[3:0], pv[7:4]}),
    .grp2_seg_sel(seg_sel), .grp2_periph_in(pi2), .grp3_universal_port_multiplexer_out(~pv),
    .grp3_universal_port_multiplexer_oe(poe), .grp3_universal_port_multiplexer_sel(up3_sel), .grp3_periph_in(pi3),
    .grp2_irq(g2_irq), .grp3_irq(g3_irq));
  gpp_pin_model i_pins (.mclk(mclk), .ext_en(ext_en), .ext_val(ext_val),
    .pin_out({g3_out, g2_out}), .pin_oe({g3_oe, g2_oe}), .pull_up({g3_pu, g2_pu}),
    .pull_down({g3_pd, g2_pd}), .pin_in(pin_in));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic irq_is(input logic [3:0] b, input logic e);
    chk({15'h0000, b[3] ? g3_irq : g2_irq}, {15'h0000, e});
  endtask
  task automatic do_reset(input logic sp);
    @(posedge mclk);
    reset <= 1'b1;
    small_pkg <= sp;
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
  endtask
  task automatic t_reset;
    logic [15:0] d;
    for (int a = 0; a < 16; a++) begin
      rd(a[3:0], d);
      chk(d, 16'h0000);
    end
  endtask
  task automatic t_gpio;
    logic [15:0] d;
    wr(`GPP_P2_DIR_EN, 16'h00ff);
    wr(`GPP_P2_PIN_DATA, 16'h5a00);
    wr(`GPP_P2_PULL, 16'hf0ff);
    rd(`GPP_P2_PIN_DATA, d);
    chk(d, 16'h5a00);
    chk({g2_oe, g2_out}, 16'hff5a);
    chk({g2_pu, g2_pd}, 16'h0000);
    wr(`GPP_P2_DIR_EN, 16'hff00);
    cyc(1);
    chk({g2_oe, g2_pu}, 16'h00f0);
    rd(`GPP_P2_PIN_DATA, d);
    chk(d, 16'h5af0);
    wr(`GPP_P2_DIR_EN, 16'h0000);
    wr(`GPP_P2_PULL, 16'h0000);
  endtask
  task automatic t_irq(input logic [3:0] b);
    logic [15:0] d;
    ext_en <= 16'hffff;
    ext_val <= 16'h0202;
    wr(`GPP_P2_DIR_EN | b, 16'hff00);
    wr(`GPP_P2_IRQ_CTL | b, 16'h0203);
    wr(`GPP_P2_IRQ_FLAGS | b, 16'h00ff);
    cyc(2);
    irq_is(b, 1'b0);
    ext_val <= 16'h0303;
    cyc(3);
    irq_is(b, 1'b1);
    wr(`GPP_P2_IRQ_FLAGS | b, 16'h0000);
    rd(`GPP_P2_IRQ_FLAGS | b, d);
    chk(d, 16'h0001);
    wr(`GPP_P2_IRQ_FLAGS | b, 16'h0001);
    cyc(1);
    irq_is(b, 1'b0);
    ext_val <= 16'h0101;
    cyc(3);
    irq_is(b, 1'b1);
    rd(`GPP_P2_IRQ_FLAGS | b, d);
    chk(d, 16'h0002);
    wr(`GPP_P2_IRQ_CTL | b, 16'h0000);
    wr(`GPP_P2_IRQ_FLAGS | b, 16'h00ff);
    wr(`GPP_P2_DIR_EN | b, 16'h0000);
  endtask
  task automatic t_func;
    logic [15:0] s2 [4] = '{16'hff00, 16'h00ff, 16'h0000, 16'h0000};
    logic [15:0] s3 [4] = '{16'h0000, 16'h00ff, 16'h0000, 16'hff00};
    logic [15:0] oe [4] = '{16'hff00, 16'hffff, 16'h0000, 16'hff00};
    logic [15:0] po [4] = '{16'h3600, 16'hc9c9, 16'h0000, 16'h6300};
    logic [15:0] pi [4] = '{16'h3600, 16'hc9c9, 16'h0000, 16'h0000};
    ext_en <= 16'h0000;
    // GPIO drive on, so a function must override it
    wr(`GPP_P2_DIR_EN, 16'h00ff);
    wr(`GPP_P2_MODE_SEL, 16'h00ff);
    wr(`GPP_P3_MODE_SEL, 16'h00ff);
    for (int c = 0; c < 4; c++) begin
      wr(`GPP_P2_FUNC_SEL, {8{c[1:0]}});
      wr(`GPP_P3_FUNC_SEL, {8{c[1:0]}});
      cyc(1);
      chk({fn0_sel, up2_sel}, s2[c]);
      chk({seg_sel, up3_sel}, s3[c]);
      chk({g2_oe, g3_oe}, oe[c]);
      chk({g2_oe & g2_out, g3_oe & g3_out}, po[c]);
      // Peripheral input lags the pin drive by one cycle
      cyc(1);
      chk({pi2, pi3}, pi[c]);
    end
    wr(`GPP_P2_MODE_SEL, 16'h0000);
    cyc(1);
    chk({fn0_sel | up2_sel | seg_sel, g2_oe}, 16'h00ff);
  endtask
  task automatic t_small;
    logic [15:0] d;
    do_reset(1'b1);
    wr(`GPP_P3_MODE_SEL, 16'h00ff);
    wr(`GPP_P3_FUNC_SEL, 16'h5555);
    cyc(1);
    chk({8'h00, up3_sel}, 16'h00a7);
    rd(`GPP_P3_MODE_SEL, d);
    chk(d, 16'h00a7);
  endtask
  task automatic finish_test;
    if (failures == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    do_reset(1'b0);
    t_reset;
    t_gpio;
    t_irq(4'h0);
    t_irq(4'h8);
    t_func;
    t_small;
    finish_test;
  end
  // Whole run is well under two thousand cycles
  initial begin
    #40000;
    failures++;
    finish_test;
  end
endmodule // gpp_port_tb_top
